// ===== sfpi_core.sv
// serial flash pin front end: lane roles, pause, hardware reset, shifting
// assumes master pins are asynchronous and sck is far slower than the core
`timescale 1ns/1ps
module sfpi_core #(
	parameter bit DEDICATED_RESET = 1'b0,
	parameter int ADDR_W          = 25
) (
	input  wire logic                             I_CORE_CLK,    // core clock
	input  wire logic                             I_RESET_N,     // async reset
	input  wire sfpi_pkg::sfpi_pins_s             I_PINS,        // master pins
	input  wire sfpi_pkg::sfpi_cfg_s              I_CFG,         // lane config
	input  wire logic                             I_TX_EN,       // drive out
	input  wire logic [7:0]                       I_TX_DATA,     // next byte
	input  wire logic [ADDR_W-1:0]                I_ADDR,        // array addr
	output logic [3:0]                            O_LANE_OUT,    // lane data
	output logic [3:0]                            O_LANE_OE_N,   // low drives
	output logic [7:0]                            O_RX_DATA,     // rx byte
	output logic                                  O_RX_VALID,    // rx pulse
	output logic                                  O_TX_LOAD,     // tx taken
	output logic                                  O_PAUSED,      // frozen
	output logic                                  O_HW_RESET,    // reset mode
	output logic                                  O_SELECTED,    // active
	output logic [ADDR_W-13:0]                    O_SECTOR_IDX,  // 4K sector
	output logic [ADDR_W-16:0]                    O_BLOCK32_IDX, // 32K block
	output logic [ADDR_W-17:0]                    O_BLOCK64_IDX  // 64K block
);
	import sfpi_pkg::*;

	// refuse an array no wider than one 64 Kbyte block
	if (ADDR_W <= SFPI_BLK64_LOG2) begin : g_bad_addr
		$error("ADDR_W must exceed the 64 Kbyte block width");
	end

	// bits moved per clock edge
	function automatic logic [2:0] lane_width(input sfpi_lane_e m);
		case (m)
			LANE_DUAL: lane_width = 3'h2;
			LANE_QUAD: lane_width = 3'h4;
			default:   lane_width = 3'h1;
		endcase
	endfunction

	// shift inbound lanes into the byte, msb first
	function automatic logic [7:0] shift_in(input logic [7:0] sh,
		input logic [3:0] ln, input sfpi_lane_e m);
		case (m)
			LANE_DUAL: shift_in = {sh[5:0], ln[1:0]};
			LANE_QUAD: shift_in = {sh[3:0], ln};
			default:   shift_in = {sh[6:0], ln[0]};
		endcase
	endfunction

	// top bits of a byte placed on the outbound lanes
	function automatic logic [3:0] lanes_from(input logic [7:0] d,
		input sfpi_lane_e m);
		case (m)
			LANE_DUAL: lanes_from = {2'h0, d[7:6]};
			LANE_QUAD: lanes_from = d[7:4];
			default:   lanes_from = {2'h0, d[7], 1'h0};
		endcase
	endfunction

	// lanes driven by the device in each width
	function automatic logic [3:0] lane_drive(input sfpi_lane_e m);
		case (m)
			LANE_DUAL: lane_drive = 4'h3;
			LANE_QUAD: lane_drive = 4'hf;
			default:   lane_drive = 4'h2;
		endcase
	endfunction

	sfpi_pins_s  pin_s1;
	sfpi_pins_s  pin_s2;
	logic        sck_d;
	sfpi_state_e state;
	sfpi_state_e next_state;
	logic [7:0]  rx_sh;
	logic [7:0]  next_rx_sh;
	logic [3:0]  rx_cnt;
	logic [3:0]  next_rx_cnt;
	logic [7:0]  tx_sh;
	logic [7:0]  next_tx_sh;
	logic [3:0]  tx_cnt;
	logic [3:0]  next_tx_cnt;
	logic        seen_rise;
	logic        next_seen_rise;
	logic        driving;
	logic        next_driving;
	logic [3:0]  drive_mask;
	logic [3:0]  next_drive_mask;
	logic [3:0]  next_lane_out;
	logic [3:0]  next_lane_oe_n;
	logic [7:0]  next_rx_data;
	logic        next_rx_valid;
	logic        next_tx_load;
	logic        pause_sel;
	logic        pause_now;
	logic        hw_rst;
	logic        sck_rise;
	logic        sck_fall;
	logic [2:0]  width;
	logic [7:0]  tx_word;
	logic [3:0]  rx_sum;
	logic [3:0]  tx_sum;
	sfpi_lane_e  mode;

	// two-stage synchroniser on every master pin, plus clock history
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			pin_s1 <= SFPI_PINS_RESET;
			pin_s2 <= SFPI_PINS_RESET;
			sck_d  <= 1'b0;
		end else begin
			pin_s1 <= I_PINS;
			pin_s2 <= pin_s1;
			sck_d  <= pin_s2.sck;
		end
	end

	// pin roles, effective lane width and clock edges
	always_comb begin
		pause_sel = ~I_CFG.quad_lane_enable_bit &
			(DEDICATED_RESET | ~I_CFG.pin_function_select_bit);
		if (DEDICATED_RESET)
			hw_rst = ~pin_s2.rst_n;
		else
			hw_rst = ~I_CFG.quad_lane_enable_bit &
				I_CFG.pin_function_select_bit & ~pin_s2.lane[3];
		pause_now = pause_sel & ~pin_s2.lane[3] & ~pin_s2.cs_n;
		if (I_CFG.quad_lane_enable_bit && (I_CFG.quad_command_mode ||
			I_CFG.lane_mode == LANE_QUAD))
			mode = LANE_QUAD;
		else if (I_CFG.lane_mode == LANE_DUAL)
			mode = LANE_DUAL;
		else
			mode = LANE_SINGLE;
		width    = lane_width(mode);
		sck_rise = pin_s2.sck & ~sck_d;
		sck_fall = ~pin_s2.sck & sck_d;
	end

	// serial sequence: shifting, pause freeze, reset and deselect
	always_comb begin
		next_state      = state;
		next_rx_sh      = rx_sh;
		next_rx_cnt     = rx_cnt;
		next_tx_sh      = tx_sh;
		next_tx_cnt     = tx_cnt;
		next_seen_rise  = seen_rise;
		next_driving    = driving;
		next_drive_mask = drive_mask;
		next_lane_out   = O_LANE_OUT;
		next_rx_data    = O_RX_DATA;
		next_rx_valid   = 1'b0;
		next_tx_load    = 1'b0;
		tx_word         = tx_sh;
		rx_sum          = rx_cnt + {1'b0, width};
		tx_sum          = tx_cnt + {1'b0, width};
		if (hw_rst) begin
			next_state     = ST_WAIT_DESEL;
			next_rx_cnt    = SFPI_ZERO4;
			next_tx_cnt    = SFPI_ZERO4;
			next_seen_rise = 1'b0;
			next_driving   = 1'b0;
		end else if (pin_s2.cs_n) begin
			next_state     = ST_IDLE;
			next_rx_cnt    = SFPI_ZERO4;
			next_tx_cnt    = SFPI_ZERO4;
			next_seen_rise = 1'b0;
			next_driving   = 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					next_state = ST_ACTIVE;                   // select edge
				end
				ST_ACTIVE: begin
					if (pause_now) begin
						next_state = ST_ACTIVE;
					end else if (sck_rise) begin
						next_seen_rise = 1'b1;
						next_rx_sh = shift_in(rx_sh, pin_s2.lane, mode);
						next_rx_cnt = rx_sum;
						if (rx_sum >= SFPI_CNT_BYTE) begin
							next_rx_cnt   = SFPI_ZERO4;
							next_rx_data  = next_rx_sh;
							next_rx_valid = 1'b1;
						end
						if (!I_TX_EN)
							next_driving = 1'b0;
					end else if (sck_fall && seen_rise && I_TX_EN) begin
						if (tx_cnt == SFPI_ZERO4) begin
							tx_word      = I_TX_DATA;
							next_tx_load = 1'b1;
						end
						next_lane_out   = lanes_from(tx_word, mode);
						next_tx_sh      = tx_word << width;
						next_tx_cnt     = (tx_sum >= SFPI_CNT_BYTE) ?
							SFPI_ZERO4 : tx_sum;
						next_driving    = 1'b1;
						next_drive_mask = lane_drive(mode);
					end
				end
				ST_WAIT_DESEL: begin
					next_state = ST_WAIT_DESEL;
				end
				default: begin
					next_state = ST_WAIT_DESEL;
				end
			endcase
		end
		// enables open only while selected, not paused and not in reset
		if (next_driving && !pause_now && !hw_rst && !pin_s2.cs_n)
			next_lane_oe_n = ~next_drive_mask;
		else
			next_lane_oe_n = SFPI_LANES_OFF;
	end

	// register the sequence and every port except the sector and block numbers
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state       <= SFPI_STATE_RESET;
			rx_sh       <= SFPI_ZERO8;
			rx_cnt      <= SFPI_ZERO4;
			tx_sh       <= SFPI_ZERO8;
			tx_cnt      <= SFPI_ZERO4;
			seen_rise   <= 1'b0;
			driving     <= 1'b0;
			drive_mask  <= SFPI_ZERO4;
			O_LANE_OUT  <= SFPI_ZERO4;
			O_LANE_OE_N <= SFPI_LANES_OFF;
			O_RX_DATA   <= SFPI_ZERO8;
			O_RX_VALID  <= 1'b0;
			O_TX_LOAD   <= 1'b0;
			O_PAUSED    <= 1'b0;
			O_HW_RESET  <= 1'b0;
			O_SELECTED  <= 1'b0;
		end else begin
			state       <= next_state;
			rx_sh       <= next_rx_sh;
			rx_cnt      <= next_rx_cnt;
			tx_sh       <= next_tx_sh;
			tx_cnt      <= next_tx_cnt;
			seen_rise   <= next_seen_rise;
			driving     <= next_driving;
			drive_mask  <= next_drive_mask;
			O_LANE_OUT  <= next_lane_out;
			O_LANE_OE_N <= next_lane_oe_n;
			O_RX_DATA   <= next_rx_data;
			O_RX_VALID  <= next_rx_valid;
			O_TX_LOAD   <= next_tx_load;
			O_PAUSED    <= pause_now;
			O_HW_RESET  <= hw_rst;
			O_SELECTED  <= (next_state == ST_ACTIVE);
		end
	end

	// sector and block numbers of the presented array address
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_SECTOR_IDX  <= '0;
			O_BLOCK32_IDX <= '0;
			O_BLOCK64_IDX <= '0;
		end else begin
			O_SECTOR_IDX  <= I_ADDR[ADDR_W-1:SFPI_SECTOR_LOG2];
			O_BLOCK32_IDX <= I_ADDR[ADDR_W-1:SFPI_BLK32_LOG2];
			O_BLOCK64_IDX <= I_ADDR[ADDR_W-1:SFPI_BLK64_LOG2];
		end
	end

	// checks on the front end
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESET_N);

	sequence s_pause_release;
		O_PAUSED ##1 !O_PAUSED;
	endsequence
	property p_dedicated_pause;
		DEDICATED_RESET && !I_CFG.quad_lane_enable_bit |-> pause_sel;
	endproperty
	a_dedicated_pause: assert property (p_dedicated_pause)
		else $error("pause role lost with quad enable clear");
	property p_quad_no_pause;
		I_CFG.quad_lane_enable_bit && !pin_s2.lane[3] |=> !O_PAUSED;
	endproperty
	a_quad_no_pause: assert property (p_quad_no_pause)
		else $error("lane 3 treated as pause with quad enable set");
	// a hardware reset during a pause clears the counters on purpose
	property p_pause_freeze;
		O_PAUSED && pause_now && !hw_rst |=>
			$stable(rx_cnt) && $stable(rx_sh);
	endproperty
	a_pause_freeze: assert property (p_pause_freeze)
		else $error("sequence moved while paused");
	property p_pause_hiz;
		O_PAUSED |-> O_LANE_OE_N == SFPI_LANES_OFF;
	endproperty
	a_pause_hiz: assert property (p_pause_hiz)
		else $error("output driven while paused");
	property p_resume;
		s_pause_release ##0 (!hw_rst && !pin_s2.cs_n) |-> state == ST_ACTIVE;
	endproperty
	a_resume: assert property (p_resume)
		else $error("sequence lost across pause");
	property p_reset_hiz;
		hw_rst |=> O_HW_RESET && O_LANE_OE_N == SFPI_LANES_OFF;
	endproperty
	a_reset_hiz: assert property (p_reset_hiz)
		else $error("outputs driven in reset mode");
	property p_shared_reset;
		!DEDICATED_RESET && !I_CFG.quad_lane_enable_bit &&
			I_CFG.pin_function_select_bit && !pin_s2.lane[3] |=> O_HW_RESET;
	endproperty
	a_shared_reset: assert property (p_shared_reset)
		else $error("select bit 1 did not give reset role");
	property p_rise_sample;
		state == ST_ACTIVE && sck_rise && !pause_now && !hw_rst &&
			!pin_s2.cs_n |=> rx_sh != $past(rx_sh) || rx_cnt != $past(rx_cnt)
			|| O_RX_VALID;
	endproperty
	a_rise_sample: assert property (p_rise_sample)
		else $error("rising edge not sampled");
	property p_fall_launch;
		$changed(O_LANE_OUT) |-> $past(sck_fall);
	endproperty
	a_fall_launch: assert property (p_fall_launch)
		else $error("output changed away from falling edge");
	property p_deselect;
		pin_s2.cs_n |=> !O_SELECTED && O_LANE_OE_N == SFPI_LANES_OFF;
	endproperty
	a_deselect: assert property (p_deselect)
		else $error("device active while deselected");
	// released while deselected the sequence may already sit in idle
	property p_reset_exit;
		$fell(O_HW_RESET) |-> state != ST_ACTIVE;
	endproperty
	a_reset_exit: assert property (p_reset_exit)
		else $error("reset exit did not wait for deselect");
endmodule

// ===== sfpi_master_model.sv
// spi master model that drives the flash pin front end
// assumes the bench resolves each lane from both parties' enables
`timescale 1ns/1ps
module sfpi_master_model (
	input  wire logic       i_clk,   // core clock
	input  wire logic [3:0] i_lane,  // resolved lane levels
	output logic            o_sck,   // serial clock
	output logic            o_cs_n,  // chip select
	output logic            o_rst_n, // dedicated reset pin
	output logic [3:0]      o_lane,  // lane drive values
	output logic [3:0]      o_en     // high where master drives
);
	logic idle_lvl; // clock idle level, high for mode 3

	// idle pins: deselected, protect and pause lines high
	initial begin
		idle_lvl = 1'b0;
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_rst_n = 1'b1;
		o_lane = 4'hd;
		o_en = 4'hd;
	end

	// park the clock at its idle level, then drop chip select
	task automatic sel();
		@(posedge i_clk);
		o_sck <= idle_lvl;
		repeat (2) @(posedge i_clk);
		o_cs_n <= 1'b0;
		repeat (6) @(posedge i_clk);
	endtask

	// clock back to idle, then raise chip select
	task automatic desel();
		o_sck <= idle_lvl;
		repeat (4) @(posedge i_clk);
		o_cs_n <= 1'b1;
		repeat (6) @(posedge i_clk);
	endtask

	// edges k0..k1-1 of a byte, w bits an edge, msb first
	// read data is taken late in the high phase, well after launch
	task automatic xfer(input logic [7:0] tx, input int w, input int k0,
		input int k1, output logic [7:0] rx);
		logic [3:0] sh;
		rx = 8'h00;
		for (int k = k0; k < k1; k++) begin
			sh = 4'(tx >> (8 - w * (k + 1)));
			o_sck <= 1'b0;
			if (w == 1) begin
				o_lane[0] <= sh[0];
			end else if (w == 2) begin
				o_en <= 4'hf;
				o_lane[1:0] <= sh[1:0];
			end else begin
				o_en <= 4'hf;
				o_lane <= sh;
			end
			repeat (4) @(posedge i_clk);
			o_sck <= 1'b1;
			repeat (4) @(posedge i_clk);
			rx = {rx[6:0], i_lane[1]};
		end
		if (w > 1) begin
			o_en <= 4'hd;
			o_lane[3:2] <= 2'b11;
		end
	endtask
endmodule

// ===== sfpi_pkg.sv
// shared types and constants for the serial flash pin front end
// assumes one core clock; all pins arrive unsynchronised from the master
package sfpi_pkg;

	// lane width of a transfer
	typedef enum logic [1:0] {
		LANE_SINGLE,
		LANE_DUAL,
		LANE_QUAD
	} sfpi_lane_e;

	// serial interface state
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_WAIT_DESEL
	} sfpi_state_e;

	// pins as seen from the master side
	typedef struct packed {
		logic       sck;
		logic       cs_n;
		logic       rst_n;
		logic [3:0] lane;
	} sfpi_pins_s;

	// configuration bits held elsewhere in the device
	typedef struct packed {
		logic       quad_lane_enable_bit;
		logic       pin_function_select_bit;
		logic       quad_command_mode;
		sfpi_lane_e lane_mode;
	} sfpi_cfg_s;

	localparam int          SFPI_BYTE_W      = 8;
	localparam int          SFPI_ADDR_W      = 25;
	localparam int          SFPI_SECTOR_LOG2 = 12;
	localparam int          SFPI_BLK32_LOG2  = 15;
	localparam int          SFPI_BLK64_LOG2  = 16;
	localparam logic [3:0]  SFPI_CNT_BYTE    = 4'h8;
	localparam logic [3:0]  SFPI_LANES_OFF   = 4'hf;
	localparam logic [3:0]  SFPI_ZERO4       = 4'h0;
	localparam logic [7:0]  SFPI_ZERO8       = 8'h00;
	localparam sfpi_pins_s  SFPI_PINS_RESET  = 7'h3f;
	localparam sfpi_state_e SFPI_STATE_RESET = ST_WAIT_DESEL;

endpackage

// ===== test_sfpi_core.sv
// bench for the flash pin front end: byte traffic via a master model
// assumes sfpi_pkg and sfpi_master_model are compiled first
`timescale 1ns/1ps
module test_sfpi_core;
	import sfpi_pkg::*;
	localparam sfpi_cfg_s cfg_plain = '{1'b0, 1'b0, 1'b0, LANE_SINGLE};
	sfpi_cfg_s  cfg_tab [5] = '{cfg_plain, cfg_plain,
		'{1'b0, 1'b0, 1'b0, LANE_DUAL}, '{1'b1, 1'b0, 1'b0, LANE_QUAD},
		'{1'b1, 1'b0, 1'b1, LANE_SINGLE}};
	logic [7:0] byte_tab [5] = '{8'ha7, 8'h81, 8'hc6, 8'h5b, 8'h4e};
	int         wid_tab [5] = '{1, 1, 2, 4, 4};
	logic       clk, rst_n, tx_en, flt, rx_valid, paused, hw_rst, tx_load;
	logic       selected;
	logic       m_sck, m_cs_n, m_rst_n;
	logic [3:0] m_lane, m_en, lanes, lane_out, oe_n;
	logic [7:0] tx_data, rx_data, got, rx;
	logic [24:0] addr;
	logic [12:0] sec;
	logic [9:0] b32;
	logic [8:0] b64;
	sfpi_cfg_s  cfg;
	sfpi_pins_s pins;
	int         num_errors, n_tests, n_rx, cyc, n0, n_ld;

	// wire level: device first, then master, else a toggling float
	assign lanes = (~oe_n & lane_out) | (oe_n & m_en & m_lane)
		| (oe_n & ~m_en & {4{flt}});
	assign pins = {m_sck, m_cs_n, m_rst_n, lanes};

	sfpi_core sfpi_core_inst (
		.I_CORE_CLK    (clk),
		.I_RESET_N     (rst_n),
		.I_PINS        (pins),
		.I_CFG         (cfg),
		.I_TX_EN       (tx_en),
		.I_TX_DATA     (tx_data),
		.I_ADDR        (addr),
		.O_LANE_OUT    (lane_out),
		.O_LANE_OE_N   (oe_n),
		.O_RX_DATA     (rx_data),
		.O_RX_VALID    (rx_valid),
		.O_TX_LOAD     (tx_load),
		.O_PAUSED      (paused),
		.O_HW_RESET    (hw_rst),
		.O_SELECTED    (selected),
		.O_SECTOR_IDX  (sec),
		.O_BLOCK32_IDX (b32),
		.O_BLOCK64_IDX (b64)
	);

	sfpi_master_model mst (
		.i_clk   (clk),
		.i_lane  (lanes),
		.o_sck   (m_sck),
		.o_cs_n  (m_cs_n),
		.o_rst_n (m_rst_n),
		.o_lane  (m_lane),
		.o_en    (m_en)
	);

	// core clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// received bytes, float pattern and the hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		flt <= ~flt;
		if (rx_valid === 1'b1) begin
			got <= rx_data;
			n_rx <= n_rx + 1;
		end
		if (tx_load === 1'b1)
			n_ld <= n_ld + 1;
		if (cyc == 8000) begin
			num_errors++;
			give_verdict();
		end
	end

	// compare one value and count it
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// finish a byte from edge k0 and expect exactly one delivery
	task automatic rx_byte(input logic [7:0] b, input int w, input int k0);
		int n1;
		n1 = n_rx;
		mst.xfer(b, w, k0, 8 / w, rx);
		repeat (6) @(posedge clk);
		check("rx count", n_rx, n1 + 1);
		check("rx data", got, b);
	endtask

	// counts line and verdict
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// main sequence
	initial begin
		rst_n = 1'b0;
		tx_en = 1'b0;
		tx_data = 8'h3c;
		addr = 25'h0;
		cfg = cfg_plain;
		flt = 1'b0;
		got = 8'h00;
		{num_errors, n_tests, n_rx, cyc, n_ld} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		addr <= 25'h1fef123;
		repeat (3) @(posedge clk);
		check("sector", sec, 13'h1fef);
		check("block32", b32, 10'h3fd);
		check("block64", b64, 9'h1fe);
		// every lane width and both clock modes
		for (int i = 0; i < 5; i++) begin
			cfg <= cfg_tab[i];
			mst.idle_lvl <= (i == 1);
			mst.sel();
			rx_byte(byte_tab[i], wid_tab[i], 0);
			mst.desel();
		end
		cfg <= cfg_plain;
		// read one byte after a received one
		mst.sel();
		check("selected", selected, 1'b1);
		rx_byte(8'h9a, 1, 0);
		tx_en <= 1'b1;
		n0 = n_ld;
		mst.xfer(8'h00, 1, 0, 8, rx);
		check("read byte", rx, tx_data);
		check("tx loads", n_ld, n0 + 1);
		check("read enables", oe_n, 4'hd);
		mst.desel();
		check("idle enables", oe_n, 4'hf);
		check("deselected", selected, 1'b0);
		// clocks while deselected are ignored
		n0 = n_rx;
		mst.xfer(8'hff, 1, 0, 8, rx);
		repeat (6) @(posedge clk);
		check("rx deselected", n_rx, n0);
		// pause mid byte, clock through it, then resume
		mst.sel();
		mst.xfer(8'ha5, 1, 0, 4, rx);
		mst.o_lane[3] <= 1'b0;
		repeat (6) @(posedge clk);
		check("paused", paused, 1'b1);
		check("pause enables", oe_n, 4'hf);
		mst.xfer(8'h00, 1, 0, 3, rx);
		mst.o_lane[3] <= 1'b1;
		repeat (6) @(posedge clk);
		rx_byte(8'ha5, 1, 4);
		mst.desel();
		// shared pin as hardware reset, mid byte while driving
		cfg <= '{1'b0, 1'b1, 1'b0, LANE_SINGLE};
		mst.sel();
		mst.xfer(8'hff, 1, 0, 3, rx);
		mst.o_lane[3] <= 1'b0;
		repeat (6) @(posedge clk);
		check("hw reset", hw_rst, 1'b1);
		check("reset enables", oe_n, 4'hf);
		check("no pause", paused, 1'b0);
		mst.o_lane[3] <= 1'b1;
		repeat (6) @(posedge clk);
		check("reset left", hw_rst, 1'b0);
		check("wait select", selected, 1'b0);
		n0 = n_rx;
		mst.xfer(8'hff, 1, 0, 8, rx);
		repeat (6) @(posedge clk);
		check("rx before select", n_rx, n0);
		mst.desel();
		tx_en <= 1'b0;
		mst.o_rst_n <= 1'b0;
		mst.sel();
		rx_byte(8'h3b, 1, 0);
		check("pin ignored", hw_rst, 1'b0);
		mst.desel();
		give_verdict();
	end
endmodule
